// [rtl/htc_pkg.sv]
// Purpose: Shared constants, types and register map of the hard timer/counter
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Every offset is a byte address
package htc_pkg;

   // Register byte offsets
   localparam logic [7:0] HTC_OFS_CTRL    = 8'h00;
   localparam logic [7:0] HTC_OFS_TOP     = 8'h04;
   localparam logic [7:0] HTC_OFS_CMP     = 8'h08;
   localparam logic [7:0] HTC_OFS_RELOAD  = 8'h0c;
   localparam logic [7:0] HTC_OFS_COUNT   = 8'h10;
   localparam logic [7:0] HTC_OFS_CAPTURE = 8'h14;
   localparam logic [7:0] HTC_OFS_IRQ_ST  = 8'h18;
   localparam logic [7:0] HTC_OFS_IRQ_EN  = 8'h1c;
   localparam logic [7:0] HTC_OFS_IRQ_SET = 8'h20;
   localparam logic [7:0] HTC_OFS_STATUS  = 8'h24;

   // Field layout
   localparam int unsigned HTC_CNT_W      = 16;
   localparam int unsigned HTC_CTRL_W     = 12;
   localparam int unsigned HTC_RSTEN_BIT  = 12;
   localparam int unsigned HTC_IRQ_W      = 3;
   localparam int unsigned HTC_IRQ_OVF    = 0;
   localparam int unsigned HTC_IRQ_CMP    = 1;
   localparam int unsigned HTC_IRQ_CAP    = 2;
   localparam int unsigned HTC_PRESC_W    = 7;

   // Synchronised pin inputs
   localparam int unsigned HTC_SYNC_W     = 4;
   localparam int unsigned HTC_IN_TCLK    = 0;
   localparam int unsigned HTC_IN_CAP     = 1;
   localparam int unsigned HTC_IN_TRST    = 2;
   localparam int unsigned HTC_IN_SALONE  = 3;

   // Values after reset
   localparam logic [11:0] HTC_CTRL_RST   = 12'h000;
   localparam logic [15:0] HTC_TOP_RST    = 16'hffff;
   localparam logic [15:0] HTC_CMP_RST    = 16'h0000;
   localparam logic [15:0] HTC_RELOAD_RST = 16'h0000;
   localparam logic [15:0] HTC_CNT_RST    = 16'h0000;
   localparam logic [2:0]  HTC_IRQ_RST    = 3'h0;

   // Preloaded values for stand-alone operation
   localparam logic [11:0] HTC_PRE_CTRL   = 12'h184;
   localparam logic [15:0] HTC_PRE_TOP    = 16'hffff;
   localparam logic [15:0] HTC_PRE_CMP    = 16'h8000;
   localparam logic [15:0] HTC_PRE_RELOAD = 16'hffff;

   typedef enum logic [1:0] {
      HTC_MODE_WDT  = 2'b00,
      HTC_MODE_CTC  = 2'b01,
      HTC_MODE_FAST = 2'b11,
      HTC_MODE_PFC  = 2'b10
   } htc_mode_t;

   typedef struct packed {
      logic       wake_en;
      logic       cap_en;
      logic       invert;
      logic       count_down;
      logic       auto_reload;
      logic       clk_src;
      logic [2:0] presc;
      logic       run;
      htc_mode_t  mode;
   } htc_ctrl_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } htc_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } htc_apb_rsp_t;

   typedef struct packed {
      htc_ctrl_t      ctrl;
      logic [15:0]    top_buf;
      logic [15:0]    cmp_buf;
      logic [15:0]    reload;
      logic [15:0]    top_act;
      logic [15:0]    cmp_act;
      logic [15:0]    count;
      logic [15:0]    capture;
      logic           going_down;
      logic           halted;
      logic [2:0]     irq_status;
      logic [2:0]     irq_enable;
      logic           wave;
      logic           irq_out;
      logic           wake_out;
      logic           rst_pin_en;
      htc_apb_rsp_t   rsp;
   } htc_state_t;

   typedef struct packed {
      logic [HTC_SYNC_W-1:0] s1;
      logic [HTC_SYNC_W-1:0] s2;
      logic [HTC_SYNC_W-1:0] s3;
   } htc_sync_state_t;

   typedef struct packed {
      logic [HTC_PRESC_W-1:0] cnt;
      logic                   tick;
   } htc_presc_state_t;

endpackage

// [rtl/htc_prescaler.sv]
// Purpose: Clock source select and power-of-two prescaler for the counter
// Assumes: ext_rise is a one-cycle pulse already synchronised to pclk
// Notes:   tick is a one-cycle pulse, one per 2**presc source events
`timescale 1ns/1ps
module htc_prescaler (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clear,
   input  wire logic       src_sel,
   input  wire logic       ext_rise,
   input  wire logic [2:0] presc,
   output logic            tick
);

   htc_pkg::htc_presc_state_t s_reg;
   htc_pkg::htc_presc_state_t s_next;
   logic                                  event_in;
   logic [htc_pkg::HTC_PRESC_W-1:0]       limit;

   always_comb begin
      event_in    = src_sel ? ext_rise : 1'b1;
      limit       = ~({htc_pkg::HTC_PRESC_W{1'b1}} << presc);
      s_next      = s_reg;
      s_next.tick = 1'b0;
      if (clear) begin
         s_next.cnt = '0;
      end else if (event_in) begin
         if (s_reg.cnt >= limit) begin
            s_next.cnt  = '0;
            s_next.tick = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;

endmodule // htc_prescaler

// [rtl/htc_sync.sv]
// Purpose: Two-flop synchronisers with rising-edge detect for the pin inputs
// Assumes: Inputs are asynchronous to pclk
// Notes:   Edge detect looks only at the second and third flops
`timescale 1ns/1ps
module htc_sync (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic [htc_pkg::HTC_SYNC_W-1:0] pins,
   output logic      [htc_pkg::HTC_SYNC_W-1:0] level,
   output logic      [htc_pkg::HTC_SYNC_W-1:0] rise
);

   htc_pkg::htc_sync_state_t s_reg;
   htc_pkg::htc_sync_state_t s_next;

   always_comb begin
      s_next    = s_reg;
      s_next.s1 = pins;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign level = s_reg.s2;
   assign rise  = s_reg.s2 & ~s_reg.s3;

endmodule // htc_sync

// [rtl/htc_timer.sv]
// Purpose: Hard 16-bit timer/counter with compare, capture, PWM and APB registers
// Assumes: One clock pclk; all pin inputs pass through htc_sync
// Notes:   Waveform, interrupt and bus answers all come from the state register
// Functional notes
// [R1] A 16-bit counter that counts up or down.
// [R2] Four modes: watchdog, clear on compare, fast PWM, phase/frequency correct PWM.
// [R3] Compare units act independently; PWM appears on the waveform output.
// [R4] PWM is glitch free; period is programmable through the top value.
// [R5] Clock source is selectable and divided by a programmable prescaler.
// [R6] Non-PWM modes: synchronised capture rising edge copies count into capture register.
// [R7] Three interrupt sources: overflow, compare match, input capture.
// [R8] Without the bus, the interrupt output is the overflow flag.
// [R9] With the bus, status, enable and set registers drive the interrupt.
// [R10] One static interrupt output plus a separate wake-up interrupt.
// [R11] Control and status registers are read and written over the bus.
// [R12] Stand-alone mode uses preloaded control values and a direct reset input.
// [R13] The reset pin enable is preloaded and always on.
// [R14] Auto reload restarts from reload value after terminal count, flagging overflow.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module htc_timer (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire htc_pkg::htc_apb_req_t apb_req,
   output htc_pkg::htc_apb_rsp_t      apb_rsp,
   input  wire logic                  timer_clock_in,
   input  wire logic                  timer_reset_n_in,
   input  wire logic                  capture_trigger_in,
   input  wire logic                  standalone_mode,
   output logic                       timer_irq_out,
   output logic                       wake_irq_out,
   output logic                       waveform_out,
   output logic [15:0]                count_value,
   output logic                       reset_pin_enable
);

   htc_pkg::htc_state_t               s_reg;
   htc_pkg::htc_state_t               s_next;
   logic [htc_pkg::HTC_SYNC_W-1:0]    pin_level;
   logic [htc_pkg::HTC_SYNC_W-1:0]    pin_rise;
   logic                              tick;
   logic                              presc_clear;
   logic                              access;
   logic                              wr;
   logic                              salone;
   logic                              trst;
   logic                              pwm_mode;
   logic [2:0]                        ev;
   logic [2:0]                        w1c;
   logic [2:0]                        w1s;
   logic [31:0]                       rdata;

   // Mapped register check, shared by the read and write paths
   function automatic logic htc_hit(input logic [7:0] a);
      case (a)
         htc_pkg::HTC_OFS_CTRL,
         htc_pkg::HTC_OFS_TOP,
         htc_pkg::HTC_OFS_CMP,
         htc_pkg::HTC_OFS_RELOAD,
         htc_pkg::HTC_OFS_COUNT,
         htc_pkg::HTC_OFS_CAPTURE,
         htc_pkg::HTC_OFS_IRQ_ST,
         htc_pkg::HTC_OFS_IRQ_EN,
         htc_pkg::HTC_OFS_IRQ_SET,
         htc_pkg::HTC_OFS_STATUS: htc_hit = 1'b1;
         default:                 htc_hit = 1'b0;
      endcase
   endfunction

   htc_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pins    ({standalone_mode, timer_reset_n_in, capture_trigger_in, timer_clock_in}),
      .level   (pin_level),
      .rise    (pin_rise)
   );

   htc_prescaler u_presc (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (presc_clear),
      .src_sel  (s_reg.ctrl.clk_src),                       // [R5]
      .ext_rise (pin_rise[htc_pkg::HTC_IN_TCLK]),
      .presc    (s_reg.ctrl.presc),                         // [R5]
      .tick     (tick)
   );

   always_comb begin
      salone      = pin_level[htc_pkg::HTC_IN_SALONE];
      // Reset pin acts whenever its enable is set, which it always is
      trst        = s_reg.rst_pin_en & ~pin_level[htc_pkg::HTC_IN_TRST];  // [R12] [R13]
      presc_clear = trst | ~s_reg.ctrl.run;
      pwm_mode    = (s_reg.ctrl.mode == htc_pkg::HTC_MODE_FAST) ||
                    (s_reg.ctrl.mode == htc_pkg::HTC_MODE_PFC);
      access      = apb_req.psel & apb_req.penable;
      // Write takes effect at the edge where pready is seen high
      wr          = access & s_reg.rsp.pready & apb_req.pwrite & htc_hit(apb_req.paddr);  // [R11]
      ev          = 3'h0;
      w1c         = 3'h0;
      w1s         = 3'h0;

      // Read multiplexer
      case (apb_req.paddr)
         htc_pkg::HTC_OFS_CTRL:    rdata = {19'h0, s_reg.rst_pin_en, s_reg.ctrl};
         htc_pkg::HTC_OFS_TOP:     rdata = {16'h0, s_reg.top_buf};
         htc_pkg::HTC_OFS_CMP:     rdata = {16'h0, s_reg.cmp_buf};
         htc_pkg::HTC_OFS_RELOAD:  rdata = {16'h0, s_reg.reload};
         htc_pkg::HTC_OFS_COUNT:   rdata = {16'h0, s_reg.count};
         htc_pkg::HTC_OFS_CAPTURE: rdata = {16'h0, s_reg.capture};
         htc_pkg::HTC_OFS_IRQ_ST:  rdata = {29'h0, s_reg.irq_status};
         htc_pkg::HTC_OFS_IRQ_EN:  rdata = {29'h0, s_reg.irq_enable};
         htc_pkg::HTC_OFS_IRQ_SET: rdata = 32'h0000_0000;
         htc_pkg::HTC_OFS_STATUS:  rdata = {29'h0, salone, s_reg.going_down, s_reg.wave};
         default:                  rdata = 32'h0000_0000;
      endcase

      s_next            = s_reg;
      s_next.rst_pin_en = 1'b1;                                        // [R13]

      // Bus answer: one wait state, then pready for one cycle
      s_next.rsp.pready  = access & ~s_reg.rsp.pready;                 // [R11]
      s_next.rsp.pslverr = access & ~s_reg.rsp.pready & ~htc_hit(apb_req.paddr);
      if (access && !s_reg.rsp.pready) begin
         s_next.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;  // [R11]
      end

      // Register writes
      if (wr) begin
         case (apb_req.paddr)
            htc_pkg::HTC_OFS_CTRL: begin
               s_next.ctrl = htc_pkg::htc_ctrl_t'(apb_req.pwdata[htc_pkg::HTC_CTRL_W-1:0]);
               if (s_next.ctrl.mode != s_reg.ctrl.mode) begin
                  s_next.count      = htc_pkg::HTC_CNT_RST;
                  s_next.going_down = 1'b0;
                  s_next.halted     = 1'b0;
                  s_next.top_act    = s_reg.top_buf;
                  s_next.cmp_act    = s_reg.cmp_buf;
               end
            end
            htc_pkg::HTC_OFS_TOP:     s_next.top_buf = apb_req.pwdata[15:0];
            htc_pkg::HTC_OFS_CMP:     s_next.cmp_buf = apb_req.pwdata[15:0];
            htc_pkg::HTC_OFS_RELOAD:  s_next.reload  = apb_req.pwdata[15:0];
            htc_pkg::HTC_OFS_COUNT: begin
               // Also the watchdog kick: reloads and releases a halted count
               s_next.count  = apb_req.pwdata[15:0];
               s_next.halted = 1'b0;
            end
            htc_pkg::HTC_OFS_IRQ_ST:  w1c = apb_req.pwdata[2:0];
            htc_pkg::HTC_OFS_IRQ_EN:  s_next.irq_enable = apb_req.pwdata[2:0];
            htc_pkg::HTC_OFS_IRQ_SET: w1s = apb_req.pwdata[2:0];
            default: begin
            end
         endcase
      end

      // Non-PWM modes use new top and compare at once
      if (!pwm_mode) begin
         s_next.top_act = s_next.top_buf;
         s_next.cmp_act = s_next.cmp_buf;
      end

      // Counting engine
      if (s_reg.ctrl.run && tick && !s_reg.halted && !trst) begin
         case (s_reg.ctrl.mode)
            htc_pkg::HTC_MODE_WDT: begin
               if (s_reg.ctrl.count_down ? (s_reg.count == 16'h0000)
                                         : (s_reg.count == s_reg.top_act)) begin
                  ev[htc_pkg::HTC_IRQ_OVF] = 1'b1;                     // [R7] [R14]
                  s_next.wave = ~s_reg.wave;
                  if (s_reg.ctrl.auto_reload) begin
                     s_next.count = s_reg.reload;                      // [R14]
                  end else begin
                     s_next.halted = 1'b1;
                  end
               end else if (s_reg.ctrl.count_down) begin
                  s_next.count = s_reg.count - 16'h0001;               // [R1]
               end else begin
                  s_next.count = s_reg.count + 16'h0001;               // [R1]
               end
            end
            htc_pkg::HTC_MODE_CTC: begin
               if (s_reg.count == s_reg.cmp_act) begin
                  ev[htc_pkg::HTC_IRQ_CMP] = 1'b1;                     // [R3] [R7]
                  s_next.wave  = ~s_reg.wave;
                  s_next.count = s_reg.ctrl.auto_reload ? s_reg.reload : 16'h0000;  // [R2] [R14]
               end else if (s_reg.count == 16'hffff) begin
                  ev[htc_pkg::HTC_IRQ_OVF] = 1'b1;                     // [R7]
                  s_next.count = s_reg.ctrl.auto_reload ? s_reg.reload : 16'h0000;  // [R14]
               end else begin
                  s_next.count = s_reg.count + 16'h0001;
               end
            end
            htc_pkg::HTC_MODE_FAST: begin
               if (s_reg.count == s_reg.cmp_act) begin
                  ev[htc_pkg::HTC_IRQ_CMP] = 1'b1;                     // [R3]
               end
               if (s_reg.count >= s_reg.top_act) begin
                  // Period boundary: only here do new top and compare take hold
                  ev[htc_pkg::HTC_IRQ_OVF] = 1'b1;
                  s_next.count   = 16'h0000;
                  s_next.top_act = s_next.top_buf;                     // [R4]
                  s_next.cmp_act = s_next.cmp_buf;                     // [R4]
               end else begin
                  s_next.count = s_reg.count + 16'h0001;
               end
            end
            htc_pkg::HTC_MODE_PFC: begin
               if (s_reg.count == s_reg.cmp_act) begin
                  ev[htc_pkg::HTC_IRQ_CMP] = 1'b1;                     // [R3]
               end
               if (!s_reg.going_down) begin
                  if (s_reg.count >= s_reg.top_act) begin
                     s_next.going_down = 1'b1;
                     if (s_reg.count != 16'h0000) begin
                        s_next.count = s_reg.count - 16'h0001;         // [R1]
                     end
                  end else begin
                     s_next.count = s_reg.count + 16'h0001;
                  end
               end else if (s_reg.count == 16'h0000) begin
                  // Bottom of the triangle: overflow and buffer update
                  ev[htc_pkg::HTC_IRQ_OVF] = 1'b1;
                  s_next.going_down = 1'b0;
                  s_next.top_act    = s_next.top_buf;                  // [R4]
                  s_next.cmp_act    = s_next.cmp_buf;                  // [R4]
                  if (s_next.top_buf != 16'h0000) begin
                     s_next.count = 16'h0001;
                  end
               end else begin
                  s_next.count = s_reg.count - 16'h0001;
               end
            end
            default: begin
               s_next.count = s_reg.count;
            end
         endcase
      end

      // PWM level follows the next count against the next active compare
      if (pwm_mode) begin
         s_next.wave = (s_next.count < s_next.cmp_act) ^ s_reg.ctrl.invert;  // [R2] [R3] [R4]
      end

      // Time stamp on a synchronised rising edge of the capture pin
      if (!pwm_mode && s_reg.ctrl.cap_en && pin_rise[htc_pkg::HTC_IN_CAP]) begin
         s_next.capture           = s_reg.count;                       // [R6]
         ev[htc_pkg::HTC_IRQ_CAP] = 1'b1;                              // [R6] [R7]
      end

      // Direct reset pin clears the count and its sequencing state
      if (trst) begin
         s_next.count      = htc_pkg::HTC_CNT_RST;                     // [R12]
         s_next.going_down = 1'b0;
         s_next.halted     = 1'b0;
         s_next.wave       = s_reg.ctrl.invert;
      end

      // A hardware event in the same cycle as its clear keeps the flag set
      s_next.irq_status = (s_reg.irq_status & ~w1c) | w1s | ev;        // [R7] [R9]

      // Stand-alone: preloaded control, reset pin clears the flags too
      if (salone) begin
         s_next.ctrl    = htc_pkg::htc_ctrl_t'(htc_pkg::HTC_PRE_CTRL); // [R12]
         s_next.top_buf = htc_pkg::HTC_PRE_TOP;                        // [R12]
         s_next.cmp_buf = htc_pkg::HTC_PRE_CMP;                        // [R12]
         s_next.reload  = htc_pkg::HTC_PRE_RELOAD;                     // [R12]
         if (trst) begin
            s_next.irq_status = htc_pkg::HTC_IRQ_RST;
         end
         s_next.irq_out = s_next.irq_status[htc_pkg::HTC_IRQ_OVF];     // [R8]
      end else begin
         s_next.irq_out = |(s_next.irq_status & s_next.irq_enable);    // [R9] [R10]
      end

      s_next.wake_out = s_next.irq_out & s_next.ctrl.wake_en;          // [R10]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg            <= '0;
         s_reg.ctrl       <= htc_pkg::htc_ctrl_t'(htc_pkg::HTC_CTRL_RST);
         s_reg.top_buf    <= htc_pkg::HTC_TOP_RST;
         s_reg.cmp_buf    <= htc_pkg::HTC_CMP_RST;
         s_reg.reload     <= htc_pkg::HTC_RELOAD_RST;
         s_reg.top_act    <= htc_pkg::HTC_TOP_RST;
         s_reg.cmp_act    <= htc_pkg::HTC_CMP_RST;
         s_reg.count      <= htc_pkg::HTC_CNT_RST;
         s_reg.irq_status <= htc_pkg::HTC_IRQ_RST;
         s_reg.irq_enable <= htc_pkg::HTC_IRQ_RST;
         s_reg.rst_pin_en <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign apb_rsp          = s_reg.rsp;
   assign timer_irq_out    = s_reg.irq_out;
   assign wake_irq_out     = s_reg.wake_out;
   assign waveform_out     = s_reg.wave;
   assign count_value      = s_reg.count;
   assign reset_pin_enable = s_reg.rst_pin_en;

endmodule // htc_timer

// [verif/htc_timer_chk.sv]
// Purpose: Port checks on the hard timer
// Assumes: Ports as declared by htc_timer
// Notes:   Bound to every htc_timer
`timescale 1ns/1ps
module htc_timer_chk (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire htc_pkg::htc_apb_req_t apb_req,
   input wire htc_pkg::htc_apb_rsp_t apb_rsp,
   input wire logic                  timer_clock_in,
   input wire logic                  timer_reset_n_in,
   input wire logic                  capture_trigger_in,
   input wire logic                  standalone_mode,
   input wire logic                  timer_irq_out,
   input wire logic                  wake_irq_out,
   input wire logic                  waveform_out,
   input wire logic [15:0]           count_value,
   input wire logic                  reset_pin_enable
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_rst_pin_on: assert property (reset_pin_enable) else $error("reset pin enable low");
   a_ready_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
      else $error("no single wait state");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready too long");
   a_ready_cause: assert property (apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable))
      else $error("pready without access");
   a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready) else $error("pslverr alone");
   a_err_data: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0) else $error("error data");
   a_wake_irq: assert property (wake_irq_out |-> timer_irq_out) else $error("wake without irq");
   a_pin_clear: assert property (!timer_reset_n_in [*3] |=> count_value == 16'h0000)
      else $error("count not cleared");
endmodule // htc_timer_chk
bind htc_timer htc_timer_chk htc_timer_chk_inst (.pclk, .presetn, .apb_req, .apb_rsp, .timer_clock_in,
   .timer_reset_n_in, .capture_trigger_in, .standalone_mode, .timer_irq_out, .wake_irq_out,
   .waveform_out, .count_value, .reset_pin_enable);

// [verif/htc_user_model.sv]
// Purpose: User logic model that masters the register bus of the timer
// Assumes: Called right after a rising pclk edge
// Notes:   One transfer at a time, idle cycle after each
`timescale 1ns/1ps
module htc_user_model (
   input  wire logic                  pclk,
   output htc_pkg::htc_apb_req_t      apb_req,
   input  wire htc_pkg::htc_apb_rsp_t apb_rsp
);
   initial apb_req = '0;
   // Request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      // No cycle count assumed: only the bench watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (apb_rsp.pready !== 1'b1);
      q = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge pclk);
   endtask
endmodule // htc_user_model

// [verif/test_hard_timer_counter_pwm.sv]
// Purpose: Self-checking bench of the hard timer
// Assumes: Inputs change by NBA at the rising edge
// Notes:   Reset table first, then hand-written cases
`timescale 1ns/1ps
module test_hard_timer_counter_pwm;
   logic                  pclk = 1'b0, presetn = 1'b0, timer_clock_in = 1'b0, timer_reset_n_in = 1'b1;
   logic                  capture_trigger_in = 1'b0, standalone_mode = 1'b0;
   htc_pkg::htc_apb_req_t apb_req;
   htc_pkg::htc_apb_rsp_t apb_rsp;
   logic                  timer_irq_out, wake_irq_out, waveform_out, reset_pin_enable;
   logic [15:0]           count_value;
   logic [31:0]           q;
   logic                  e;
   logic [15:0]           pc = 16'h0;
   int                    n_fail = 0, tests_run = 0;
   // Address, reset value, error
   localparam logic [40:0] ROWS [11] = '{{8'h00, 32'h1000, 1'b0}, {8'h04, 32'hffff, 1'b0},
      {8'h08, 32'h0, 1'b0}, {8'h0c, 32'h0, 1'b0}, {8'h10, 32'h0, 1'b0}, {8'h14, 32'h0, 1'b0},
      {8'h18, 32'h0, 1'b0}, {8'h1c, 32'h0, 1'b0}, {8'h20, 32'h0, 1'b0}, {8'h24, 32'h0, 1'b0},
      {8'h28, 32'h0, 1'b1}};
   always #10 pclk = ~pclk;
   htc_user_model htc_user_model_inst (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));
   htc_timer htc_timer_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .timer_clock_in(timer_clock_in), .timer_reset_n_in(timer_reset_n_in),
      .capture_trigger_in(capture_trigger_in), .standalone_mode(standalone_mode),
      .timer_irq_out(timer_irq_out), .wake_irq_out(wake_irq_out), .waveform_out(waveform_out),
      .count_value(count_value), .reset_pin_enable(reset_pin_enable));
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         n_fail++;
         $display("ERROR %0t mismatch got %h exp %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      htc_user_model_inst.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic xe);
      htc_user_model_inst.xfer(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk(32'(e), 32'(xe));
   endtask
   task automatic conclude;
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   initial begin
      #200000;
      n_fail++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(32'(reset_pin_enable), 32'h1);
      foreach (ROWS[i]) rc(ROWS[i][40:33], ROWS[i][32:1], ROWS[i][0]);
      // Fast PWM: top 2, compare 1, overflow enabled
      wr(8'h04, 32'h2);
      wr(8'h08, 32'h1);
      wr(8'h1c, 32'h1);
      wr(8'h00, 32'h7);
      repeat (20) begin
         settle(0);
         chk(32'(count_value <= 16'h2), 32'h1);
         chk(32'(waveform_out), 32'(count_value < 16'h1));
         @(posedge pclk);
      end
      chk(32'(timer_irq_out), 32'h1);
      wr(8'h00, 32'h3);
      rc(8'h18, 32'h3, 1'b0);
      wr(8'h18, 32'h7);
      rc(8'h18, 32'h0, 1'b0);
      wr(8'h20, 32'h4);
      settle(2);
      chk(32'(timer_irq_out), 32'h0);
      @(posedge pclk);
      wr(8'h1c, 32'h4);
      settle(2);
      chk(32'({timer_irq_out, wake_irq_out}), 32'h2);
      @(posedge pclk);
      wr(8'h00, 32'h803);
      settle(2);
      chk(32'(wake_irq_out), 32'h1);
      @(posedge pclk);
      wr(8'h18, 32'h7);
      // Phase/frequency correct PWM: count runs 1, 2, 1, 0 and wave is high below compare
      wr(8'h00, 32'h6);
      repeat (12) begin
         settle(0);
         chk(32'(count_value <= 16'h2), 32'h1);
         chk(32'(waveform_out), 32'(count_value < 16'h1));
         if (pc == 16'h2) chk(32'(count_value), 32'h1);
         pc = count_value;
         @(posedge pclk);
      end
      wr(8'h00, 32'h0);
      wr(8'h18, 32'h7);
      // Capture in clear-on-compare mode
      wr(8'h00, 32'h0);
      wr(8'h08, 32'hffff);
      wr(8'h00, 32'h405);
      repeat (10) @(posedge pclk);
      capture_trigger_in <= 1'b1;
      repeat (4) @(posedge pclk);
      capture_trigger_in <= 1'b0;
      htc_user_model_inst.xfer(1'b0, 8'h14, 32'h0, q, e);
      chk(32'(q != 32'h0), 32'h1);
      rc(8'h18, 32'h4, 1'b0);
      // External count source, five rising edges
      wr(8'h00, 32'h0);
      wr(8'h00, 32'h45);
      repeat (5) begin
         timer_clock_in <= 1'b1;
         repeat (4) @(posedge pclk);
         timer_clock_in <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      chk(32'(count_value), 32'h5);
      timer_reset_n_in <= 1'b0;
      settle(4);
      chk(32'(count_value), 32'h0);
      @(posedge pclk);
      timer_reset_n_in <= 1'b1;
      standalone_mode <= 1'b1;
      repeat (4) @(posedge pclk);
      rc(8'h00, 32'h1184, 1'b0);
      for (int i = 0; i < 100 && timer_irq_out !== 1'b1; i++) @(posedge pclk);
      chk(32'(timer_irq_out), 32'h1);
      conclude();
   end
endmodule // test_hard_timer_counter_pwm
